// >>> src/adcc_map.svh
// adc control block: register offsets, field positions, reset values
// assumes: included by adcc_top only, byte-wide register port
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// ****************************************
// register offsets (register port index)
// ****************************************
`define ADCC_OFF_CONVERSION_CONTROL   4'h0
`define ADCC_OFF_PIN_REFERENCE_CONFIG 4'h1
`define ADCC_OFF_FORMAT_CLOCK_CONFIG  4'h2
`define ADCC_OFF_RESULT_HIGH_BYTE     4'h3
`define ADCC_OFF_RESULT_LOW_BYTE      4'h4
`define ADCC_OFF_IRQ_STATUS           4'h5
`define ADCC_OFF_IRQ_MASK             4'h6

// ****************************************
// field positions
// ****************************************
`define ADCC_CC_ENABLE_BIT     0
`define ADCC_CC_GO_BIT         1
`define ADCC_CC_CHAN_LSB       2
`define ADCC_CC_CHAN_MSB       5
`define ADCC_PR_PCFG_LSB       0
`define ADCC_PR_PCFG_MSB       3
`define ADCC_PR_REFPOS_BIT     4
`define ADCC_PR_REFNEG_BIT     5
`define ADCC_FC_CLKSEL_LSB     0
`define ADCC_FC_CLKSEL_MSB     2
`define ADCC_FC_JUSTIFY_BIT    7
`define ADCC_IRQ_DONE_BIT      0

// ****************************************
// writable masks and reset values
// ****************************************
`define ADCC_CC_WMASK          8'h3F
`define ADCC_PR_WMASK          8'h3F
`define ADCC_FC_WMASK          8'h87
`define ADCC_IRQ_WMASK         8'h01
`define ADCC_REG_RESET         8'h00

// ****************************************
// divider last counts (divide by n -> n-1)
// ****************************************
`define ADCC_DIV2_LAST         6'h01
`define ADCC_DIV4_LAST         6'h03
`define ADCC_DIV8_LAST         6'h07
`define ADCC_DIV16_LAST        6'h0F
`define ADCC_DIV32_LAST        6'h1F
`define ADCC_DIV64_LAST        6'h3F
`define ADCC_MAX_PCFG          4'hE

`endif

// >>> src/adcc_pkg.sv
// adc control block: shared types
// assumes: constants come from adcc_map.svh
package adcc_pkg;

	// conversion sequencer, gray coded
	typedef enum logic [0:0]
	{
		ADCC_IDLE = 1'b0,
		ADCC_CONV = 1'b1
	} adcc_state_t;

	// conversion clock select codes
	typedef enum logic [2:0]
	{
		ADCC_CLK_DIV2  = 3'h0,
		ADCC_CLK_DIV8  = 3'h1,
		ADCC_CLK_DIV32 = 3'h2,
		ADCC_CLK_RC_A  = 3'h3,
		ADCC_CLK_DIV4  = 3'h4,
		ADCC_CLK_DIV16 = 3'h5,
		ADCC_CLK_DIV64 = 3'h6,
		ADCC_CLK_RC_B  = 3'h7
	} adcc_clk_sel_t;

endpackage

// >>> src/adcc_top.sv
// adc control block: control registers, conversion sequencer, bit clock enable
// assumes: one clock, register port inputs and core inputs synchronous to clk
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "adcc_map.svh"

module adcc_top #(
	parameter int NUM_INPUTS = 16
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	// register port
	input  wire logic [3:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	// interrupt
	output logic                       irq,
	// converter core control
	output logic                       converter_enable,
	output logic [3:0]                 analog_channel_select,
	output logic                       channel_available,
	output logic                       ref_pos_external,
	output logic                       ref_neg_external,
	output logic [NUM_INPUTS-1:0]      pin_analog,
	output logic                       use_internal_rc_clock,
	output logic                       bit_clock_tick,
	output logic                       core_start,
	output logic                       core_abort,
	// converter core status
	input  wire logic                  internal_rc_tick,
	input  wire logic                  core_done,
	input  wire logic [9:0]            core_result
);

	// ****************************************
	// register state
	// ****************************************
	logic [7:0]                conversion_control;
	logic [7:0]                pin_reference_config;
	logic [7:0]                format_clock_config;
	logic [7:0]                result_high_byte;
	logic [7:0]                result_low_byte;
	logic [7:0]                irq_status;
	logic [7:0]                irq_mask;
	logic [7:0]                next_conversion_control;
	logic [7:0]                next_pin_reference_config;
	logic [7:0]                next_format_clock_config;
	logic [7:0]                next_result_high_byte;
	logic [7:0]                next_result_low_byte;
	logic [7:0]                next_irq_status;
	logic [7:0]                next_irq_mask;
	logic [7:0]                next_reg_rdata;
	adcc_pkg::adcc_state_t     state;
	adcc_pkg::adcc_state_t     next_state;
	logic                      next_core_start;
	logic                      next_core_abort;

	logic                      wr_cc;
	logic                      start_req;
	logic                      done_evt;
	logic [3:0]                pcfg;

	assign wr_cc = reg_wr && (reg_addr == `ADCC_OFF_CONVERSION_CONTROL);
	// start needs the enable bit set in the same write as the go bit
	assign start_req = wr_cc && reg_wdata[`ADCC_CC_GO_BIT]
		&& reg_wdata[`ADCC_CC_ENABLE_BIT];
	assign done_evt = (state == adcc_pkg::ADCC_CONV) && core_done;

	// ****************************************
	// register and sequencer next values
	// ****************************************
	always_comb
	begin
		next_conversion_control   = conversion_control;
		next_pin_reference_config = pin_reference_config;
		next_format_clock_config  = format_clock_config;
		next_result_high_byte     = result_high_byte;
		next_result_low_byte      = result_low_byte;
		next_irq_status           = irq_status;
		next_irq_mask             = irq_mask;
		next_state                = state;
		next_core_start           = 1'b0;
		next_core_abort           = 1'b0;
		if (reg_wr)
		begin
			unique case (reg_addr)
				`ADCC_OFF_CONVERSION_CONTROL:
				begin
					// go bit is owned by the sequencer below
					next_conversion_control = (reg_wdata & `ADCC_CC_WMASK)
						& ~(8'h01 << `ADCC_CC_GO_BIT);
					next_conversion_control[`ADCC_CC_GO_BIT] =
						conversion_control[`ADCC_CC_GO_BIT];
				end
				`ADCC_OFF_PIN_REFERENCE_CONFIG:
					next_pin_reference_config = reg_wdata & `ADCC_PR_WMASK;
				`ADCC_OFF_FORMAT_CLOCK_CONFIG:
					next_format_clock_config = reg_wdata & `ADCC_FC_WMASK;
				`ADCC_OFF_IRQ_STATUS:
					next_irq_status = irq_status & ~(reg_wdata & `ADCC_IRQ_WMASK);
				`ADCC_OFF_IRQ_MASK:
					next_irq_mask = reg_wdata & `ADCC_IRQ_WMASK;
				default:
				begin
				end
			endcase
		end
		unique case (state)
			adcc_pkg::ADCC_IDLE:
			begin
				if (start_req)
				begin
					next_state      = adcc_pkg::ADCC_CONV;
					next_core_start = 1'b1;
					next_conversion_control[`ADCC_CC_GO_BIT] = 1'b1;
				end
			end
			adcc_pkg::ADCC_CONV:
			begin
				if (done_evt)
				begin
					// completion wins over a same-cycle abort write
					next_state = adcc_pkg::ADCC_IDLE;
					next_conversion_control[`ADCC_CC_GO_BIT] = 1'b0;
					if (format_clock_config[`ADCC_FC_JUSTIFY_BIT])
					begin
						next_result_high_byte = {6'h00, core_result[9:8]};
						next_result_low_byte  = core_result[7:0];
					end
					else
					begin
						next_result_high_byte = core_result[9:2];
						next_result_low_byte  = {core_result[1:0], 6'h00};
					end
				end
				else if (wr_cc && !(reg_wdata[`ADCC_CC_GO_BIT]
					&& reg_wdata[`ADCC_CC_ENABLE_BIT]))
				begin
					// clearing go or enable aborts the running conversion
					next_state      = adcc_pkg::ADCC_IDLE;
					next_core_abort = 1'b1;
					next_conversion_control[`ADCC_CC_GO_BIT] = 1'b0;
				end
			end
		endcase
		// set wins over a same-cycle write-one-to-clear
		if (done_evt)
		begin
			next_irq_status[`ADCC_IRQ_DONE_BIT] = 1'b1;
		end
	end

	// ****************************************
	// register and sequencer flops
	// ****************************************
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			conversion_control   <= `ADCC_REG_RESET;
			pin_reference_config <= `ADCC_REG_RESET;
			format_clock_config  <= `ADCC_REG_RESET;
			result_high_byte     <= `ADCC_REG_RESET;
			result_low_byte      <= `ADCC_REG_RESET;
			irq_status           <= `ADCC_REG_RESET;
			irq_mask             <= `ADCC_REG_RESET;
			state                <= adcc_pkg::ADCC_IDLE;
			core_start           <= 1'b0;
			core_abort           <= 1'b0;
		end
		else
		begin
			conversion_control   <= next_conversion_control;
			pin_reference_config <= next_pin_reference_config;
			format_clock_config  <= next_format_clock_config;
			result_high_byte     <= next_result_high_byte;
			result_low_byte      <= next_result_low_byte;
			irq_status           <= next_irq_status;
			irq_mask             <= next_irq_mask;
			state                <= next_state;
			core_start           <= next_core_start;
			core_abort           <= next_core_abort;
		end
	end

	// ****************************************
	// read port, data one cycle after strobe
	// ****************************************
	always_comb
	begin
		next_reg_rdata = 8'h00;
		if (reg_rd)
		begin
			unique case (reg_addr)
				`ADCC_OFF_CONVERSION_CONTROL:   next_reg_rdata = conversion_control;
				`ADCC_OFF_PIN_REFERENCE_CONFIG: next_reg_rdata = pin_reference_config;
				`ADCC_OFF_FORMAT_CLOCK_CONFIG:  next_reg_rdata = format_clock_config;
				`ADCC_OFF_RESULT_HIGH_BYTE:     next_reg_rdata = result_high_byte;
				`ADCC_OFF_RESULT_LOW_BYTE:      next_reg_rdata = result_low_byte;
				`ADCC_OFF_IRQ_STATUS:           next_reg_rdata = irq_status;
				`ADCC_OFF_IRQ_MASK:             next_reg_rdata = irq_mask;
				default:                        next_reg_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			reg_rdata <= 8'h00;
		end
		else
		begin
			reg_rdata <= next_reg_rdata;
		end
	end

	assign irq = |(irq_status & irq_mask);

	// ****************************************
	// core selections
	// ****************************************
	assign converter_enable      = conversion_control[`ADCC_CC_ENABLE_BIT];
	assign analog_channel_select =
		conversion_control[`ADCC_CC_CHAN_MSB:`ADCC_CC_CHAN_LSB];
	assign channel_available     =
		({28'h0000000, analog_channel_select} < NUM_INPUTS);
	assign ref_pos_external      = pin_reference_config[`ADCC_PR_REFPOS_BIT];
	assign ref_neg_external      = pin_reference_config[`ADCC_PR_REFNEG_BIT];
	assign pcfg = pin_reference_config[`ADCC_PR_PCFG_MSB:`ADCC_PR_PCFG_LSB];

	genvar gi;
	generate
		for (gi = 0; gi < NUM_INPUTS; gi++)
		begin : g_pin
			// analog when pcfg is zero or index plus pcfg stays at fourteen or below
			assign pin_analog[gi] = (pcfg == 4'h0)
				|| ((5'(gi) + {1'b0, pcfg}) <= {1'b0, `ADCC_MAX_PCFG});
		end
	endgenerate

	// ****************************************
	// conversion bit clock enable
	// ****************************************
	adcc_pkg::adcc_clk_sel_t   clk_sel;
	logic [5:0]                div_cnt;
	logic [5:0]                next_div_cnt;
	logic [5:0]                div_last;
	logic                      next_bit_clock_tick;

	assign clk_sel = adcc_pkg::adcc_clk_sel_t'(
		format_clock_config[`ADCC_FC_CLKSEL_MSB:`ADCC_FC_CLKSEL_LSB]);
	assign use_internal_rc_clock = (clk_sel == adcc_pkg::ADCC_CLK_RC_A)
		|| (clk_sel == adcc_pkg::ADCC_CLK_RC_B);

	always_comb
	begin
		unique case (clk_sel)
			adcc_pkg::ADCC_CLK_DIV2:  div_last = `ADCC_DIV2_LAST;
			adcc_pkg::ADCC_CLK_DIV4:  div_last = `ADCC_DIV4_LAST;
			adcc_pkg::ADCC_CLK_DIV8:  div_last = `ADCC_DIV8_LAST;
			adcc_pkg::ADCC_CLK_DIV16: div_last = `ADCC_DIV16_LAST;
			adcc_pkg::ADCC_CLK_DIV32: div_last = `ADCC_DIV32_LAST;
			adcc_pkg::ADCC_CLK_DIV64: div_last = `ADCC_DIV64_LAST;
			adcc_pkg::ADCC_CLK_RC_A,
			adcc_pkg::ADCC_CLK_RC_B:  div_last = `ADCC_DIV2_LAST;
		endcase
		next_div_cnt        = div_cnt;
		next_bit_clock_tick = 1'b0;
		if (!converter_enable)
		begin
			next_div_cnt = 6'h00;
		end
		else if (use_internal_rc_clock)
		begin
			next_div_cnt        = 6'h00;
			next_bit_clock_tick = internal_rc_tick;
		end
		else if (div_cnt >= div_last)
		begin
			next_div_cnt        = 6'h00;
			next_bit_clock_tick = 1'b1;
		end
		else
		begin
			next_div_cnt = div_cnt + 6'h01;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			div_cnt        <= 6'h00;
			bit_clock_tick <= 1'b0;
		end
		else
		begin
			div_cnt        <= next_div_cnt;
			bit_clock_tick <= next_bit_clock_tick;
		end
	end

endmodule // adcc_top

// >>> testbench/adcc_checker.sv
// port assertions for the adc control block
// assumes: bound into adcc_top, single clock domain
`timescale 1ns/1ps

module adcc_checker #(
	parameter int NUM_INPUTS = 16
) (
	// clock and reset
	input wire logic                  clk,
	input wire logic                  sys_rst,
	// register port
	input wire logic [3:0]            reg_addr,
	input wire logic [7:0]            reg_wdata,
	input wire logic                  reg_wr,
	input wire logic                  reg_rd,
	input wire logic [7:0]            reg_rdata,
	// core control
	input wire logic                  converter_enable,
	input wire logic [3:0]            analog_channel_select,
	input wire logic                  ref_pos_external,
	input wire logic                  ref_neg_external,
	input wire logic [NUM_INPUTS-1:0] pin_analog,
	input wire logic                  use_internal_rc_clock,
	input wire logic                  core_start,
	input wire logic                  core_abort
);
	logic        w0;
	logic        w1;
	logic        w2;
	logic [15:0] pin_exp;

	assign w0 = reg_wr && reg_addr == 4'h0;
	assign w1 = reg_wr && reg_addr == 4'h1;
	assign w2 = reg_wr && reg_addr == 4'h2;
	// analog pins for the code being written
	always_comb
		pin_exp = (reg_wdata[3:0] == 4'h0) ? 16'hFFFF : (16'h7FFF >> reg_wdata[3:0]);

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ****************
	// assertions
	// ****************
	chk_start_cause: assert property (
		core_start |-> $past(w0 && reg_wdata[1:0] == 2'h3)) else $error("start without write");
	chk_abort_cause: assert property (
		core_abort |-> $past(w0 && reg_wdata[1:0] != 2'h3)) else $error("abort without write");
	chk_enable_follow: assert property (
		w0 |=> converter_enable == $past(reg_wdata[0])) else $error("enable wrong");
	chk_chan_follow: assert property (
		w0 |=> analog_channel_select == $past(reg_wdata[5:2])) else $error("channel wrong");
	chk_ref_follow: assert property (
		w1 |=> {ref_neg_external, ref_pos_external} == $past(reg_wdata[5:4]))
		else $error("reference wrong");
	chk_pin_map: assert property (
		w1 |=> pin_analog == $past(pin_exp[NUM_INPUTS-1:0])) else $error("pin map wrong");
	chk_unimpl_zero: assert property (
		reg_rd && reg_addr < 4'h3 |=>
		(reg_rdata & ($past(reg_addr) == 4'h2 ? 8'h78 : 8'hC0)) == 8'h00)
		else $error("unimplemented bit set");
	chk_rc_select: assert property (
		w2 |=> use_internal_rc_clock == ($past(reg_wdata[1:0]) == 2'h3))
		else $error("rc select wrong");
endmodule // adcc_checker

// >>> testbench/adcc_core_model.sv
// behavioural converter core: counts bit ticks, returns a sample
// assumes: start and abort pulses from the control block
`timescale 1ns/1ps

module adcc_core_model (
	// clock and reset
	input wire logic       clk,
	input wire logic       sys_rst,
	// from the control block
	input wire logic       core_start,
	input wire logic       core_abort,
	input wire logic       bit_clock_tick,
	// bench controls
	input wire logic       slow,
	input wire logic [9:0] sample,
	// to the control block
	output logic           internal_rc_tick,
	output logic           core_done,
	output logic [9:0]     core_result
);
	logic       busy;
	logic [4:0] ticks;
	logic [2:0] rc_cnt;
	logic [9:0] held;

	// result lines are not valid outside the done cycle
	assign core_result = core_done ? held : ~held;

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			busy <= 1'b0;
			ticks <= 5'h00;
			rc_cnt <= 3'h0;
			core_done <= 1'b0;
			internal_rc_tick <= 1'b0;
			held <= 10'h000;
		end
		else
		begin
			rc_cnt <= rc_cnt + 3'h1;
			internal_rc_tick <= rc_cnt == 3'h7;
			core_done <= 1'b0;
			if (core_start || core_abort)
			begin
				busy <= core_start;
				ticks <= 5'h00;
			end
			else if (busy && bit_clock_tick)
			begin
				ticks <= ticks + 5'h01;
				if (ticks == (slow ? 5'h15 : 5'h0A))
				begin
					busy <= 1'b0;
					core_done <= 1'b1;
					held <= sample;
				end
			end
		end
	end
endmodule // adcc_core_model

// >>> testbench/adc_control_registers_tb.sv
// self-checking bench for the adc control block
// assumes: core model on the far side, checker bound below
`timescale 1ns/1ps

module adc_control_registers_tb;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       slow = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [9:0] sample = 10'h000;
	logic [7:0] reg_rdata;
	logic [9:0] core_result;
	localparam int NUM_INPUTS = 12;
	logic       irq, bit_clock_tick, core_start, core_abort, internal_rc_tick, core_done;
	logic       channel_available;
	logic [9:0] exp_q[$];
	logic       exp_irq = 1'b0;
	logic       exp_chan = 1'b1;
	// bit tick spacing per clock select code; rc ticks come every 8 cycles from the model
	logic [7:0] gap_tab [8] = '{8'h02, 8'h08, 8'h20, 8'h08, 8'h04, 8'h10, 8'h40, 8'h08};
	logic       rd_d = 1'b0;
	logic [3:0] ch;
	logic [7:0] fc;
	int         bad_count = 0;
	int         samples_checked = 0;
	int         i;

	always #12.5 clk = ~clk;

	adcc_top #(.NUM_INPUTS(NUM_INPUTS)) dut_u (
		.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
		.converter_enable(), .analog_channel_select(), .channel_available,
		.ref_pos_external(), .ref_neg_external(), .pin_analog(), .use_internal_rc_clock(),
		.bit_clock_tick, .core_start, .core_abort, .internal_rc_tick, .core_done, .core_result
	);
	adcc_core_model core_u (
		.clk, .sys_rst, .core_start, .core_abort, .bit_clock_tick, .slow, .sample,
		.internal_rc_tick, .core_done, .core_result
	);

	// ****************
	// tasks
	// ****************
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		if (a == 4'h0)
			exp_chan = (int'(d[5:2]) < NUM_INPUTS);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back({exp_chan, exp_irq, e});
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask
	// waits for n done pulses or n bit ticks, bounded
	task automatic wait_ev(input bit on_done, input int n);
		int seen;
		seen = 0;
		for (int c = 0; c < 3000 && seen < n; c++)
		begin
			@(posedge clk);
			if (on_done ? core_done : bit_clock_tick)
				seen++;
		end
		if (seen < n)
		begin
			bad_count++;
			report_and_stop();
		end
	endtask

	// cycles between two consecutive bit ticks, bounded
	task automatic tick_gap(input logic [7:0] e);
		int n;
		n = 0;
		wait_ev(1'b0, 1);
		do
		begin
			@(posedge clk);
			n++;
		end
		while (!bit_clock_tick && n < 200);
		cmp("tick_period", e, 8'(n));
	endtask

	// read data and irq stand in the cycle after the read strobe
	always @(posedge clk)
	begin
		rd_d <= reg_rd;
		if (rd_d && exp_q.size() > 0)
		begin
			cmp("reg_rdata", exp_q[0][7:0], reg_rdata);
			cmp("irq", {7'h00, exp_q[0][8]}, {7'h00, irq});
			cmp("channel_available", {7'h00, exp_q[0][9]}, {7'h00, channel_available});
			void'(exp_q.pop_front());
		end
	end

	// ****************
	// scenarios
	// ****************
	initial
	begin
		void'($urandom(91348));
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 7; i++)
			rd(4'(i), 8'h00);
		rd(4'hF, 8'h00);
		wr(4'h0, 8'hFD);
		rd(4'h0, 8'h3D);
		wr(4'h1, 8'hFF);
		rd(4'h1, 8'h3F);
		wr(4'h2, 8'hFF);
		rd(4'h2, 8'h87);
		wr(4'h0, 8'h02);
		rd(4'h0, 8'h00);
		for (i = 0; i < 16; i++)
		begin
			fc = 8'(($urandom_range(3) << 4) | i);
			wr(4'h1, fc);
			rd(4'h1, fc);
		end
		// every clock code, both formats, masked and unmasked
		for (i = 0; i < 8; i++)
		begin
			ch = 4'($urandom_range(15));
			sample <= 10'($urandom());
			slow <= i[0];
			wr(4'h2, {i[1], 4'h0, 3'(i)});
			wr(4'h6, {7'h00, i[2]});
			wr(4'h0, {2'h0, ch, 2'h3});
			rd(4'h0, {2'h0, ch, 2'h3});
			tick_gap(gap_tab[i]);
			wait_ev(1'b1, 1);
			exp_irq = i[2];
			rd(4'h0, {2'h0, ch, 2'h1});
			rd(4'h3, i[1] ? {6'h00, sample[9:8]} : sample[9:2]);
			rd(4'h4, i[1] ? sample[7:0] : {sample[1:0], 6'h00});
			rd(4'h5, 8'h01);
			wr(4'h5, 8'h01);
			exp_irq = 1'b0;
			wait_ev(1'b0, 2);
		end
		wr(4'h0, 8'h07);
		wr(4'h0, 8'h05);
		rd(4'h0, 8'h05);
		rd(4'h5, 8'h00);
		wr(4'h0, 8'h07);
		sys_rst <= 1'b1;
		exp_chan = 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 3; i++)
			rd(4'(i), 8'h00);
		report_and_stop();
	end
endmodule // adc_control_registers_tb

bind adcc_top adcc_checker #(.NUM_INPUTS(NUM_INPUTS)) chk_u (
	.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .converter_enable,
	.analog_channel_select, .ref_pos_external, .ref_neg_external, .pin_analog,
	.use_internal_rc_clock, .core_start, .core_abort
);
